// ### hw/scl_event_pkg.sv
// Constants for the SCL period counts and event status block.
// Assumes a 32-bit APB slave port on a single clock with an active-low reset.
package scl_event_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFFS_CONTROL       = 8'h00;
   localparam logic [7:0] OFFS_STD_SCL_HIGH  = 8'h14;
   localparam logic [7:0] OFFS_STD_SCL_LOW   = 8'h18;
   localparam logic [7:0] OFFS_FAST_SCL_HIGH = 8'h1c;
   localparam logic [7:0] OFFS_FAST_SCL_LOW  = 8'h20;
   localparam logic [7:0] OFFS_HS_SCL_HIGH   = 8'h24;
   localparam logic [7:0] OFFS_HS_SCL_LOW    = 8'h28;
   localparam logic [7:0] OFFS_MASKED_STAT   = 8'h2c;
   localparam logic [7:0] OFFS_EVENT_MASK    = 8'h30;
   localparam logic [7:0] OFFS_UNMASKED_STAT = 8'h34;
   localparam logic [7:0] OFFS_CLEAR_ALL     = 8'h40;

   // Field widths and positions.
   localparam int COUNT_W   = 16;
   localparam int EVENT_W   = 12;
   localparam int LEVEL_W   = 8;
   localparam int SPEED_LSB = 1;

   // Event bit positions.
   localparam int BIT_GEN_CALL   = 11;
   localparam int BIT_START      = 10;
   localparam int BIT_STOP       = 9;
   localparam int BIT_ACTIVITY   = 8;
   localparam int BIT_TX_DONE    = 7;
   localparam int BIT_TX_ABORT   = 6;
   localparam int BIT_READ_REQ   = 5;
   localparam int BIT_TX_LOW     = 4;
   localparam int BIT_TX_OVER    = 3;
   localparam int BIT_RX_HIGH    = 2;
   localparam int BIT_RX_OVER    = 1;
   localparam int BIT_RX_UNDER   = 0;

   // Speed field encodings.
   localparam logic [1:0] SPEED_STANDARD = 2'h1;
   localparam logic [1:0] SPEED_FAST     = 2'h2;
   localparam logic [1:0] SPEED_HIGH     = 2'h3;

   // Values after reset.
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [1:0]  SPEED_RESET = 2'h3;
   localparam logic [11:0] MASK_RESET  = 12'h8ff;
   localparam logic [11:0] EVENT_RESET = 12'h000;

endpackage

// ### hw/scl_event_regs.sv
// SCL period count registers and the twelve-source event status logic with APB access.
// Assumes event pulses and buffer levels come from logic on pclk; SDA and SCL come from pins.
//
// Function
// - Writable 16-bit standard-speed SCL high count, reset zero.
// - Writable 16-bit standard-speed SCL low count at 0x18, reset zero.
// - Writable 16-bit fast-speed SCL high count at 0x1c.
// - Writable 16-bit fast-speed SCL low count at 0x20.
// - Writable 16-bit high-speed SCL high count at 0x24.
// - Writable 16-bit high-speed SCL low count at 0x28.
// - Bit 11 set only on an acknowledged general call address.
// - Bit 10 set on START or repeated START on the bus.
// - Bit 9 set on STOP on the bus.
// - Bit 8 set on bus activity and held until cleared.
// - Bit 7 set when, as slave transmitter, master does not acknowledge.
// - Bit 6 set when a transmit cannot complete its queued actions.
// - Bit 5 set when a remote master reads from this slave.
// - Bit 4 high while transmit fill is at or below its threshold.
// - Bit 3 set on a command write while transmit buffer is full.
// - Bit 2 high while receive fill reaches or exceeds its threshold.
// - Bit 1 set when a byte arrives with the receive buffer full.
// - Bit 0 set on a data read while the receive buffer is empty.
// - Twelve writable mask bits; bits 11 and 7..0 reset one, others zero.
// - Speed field 01, 10, 11 selects standard, fast or high-speed counts.
// - Reading the clear-all register clears all sticky flags; the interrupt drops unless an unmasked level flag or an unmasked event in the clearing cycle is high.
`timescale 1ns/100ps

module scl_event_regs
   import scl_event_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                clk_en,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                sda_in,
   input  wire logic                scl_in,
   input  wire logic                gen_call_acked,
   input  wire logic                bus_active,
   input  wire logic                slave_tx_nack,
   input  wire logic                tx_abort_event,
   input  wire logic                read_request_event,
   input  wire logic                data_cmd_write,
   input  wire logic                data_cmd_read,
   input  wire logic                tx_fifo_full,
   input  wire logic                rx_fifo_full,
   input  wire logic                rx_fifo_empty,
   input  wire logic                rx_byte_arrived,
   input  wire logic [LEVEL_W-1:0]  tx_fill,
   input  wire logic [LEVEL_W-1:0]  tx_threshold,
   input  wire logic [LEVEL_W-1:0]  rx_fill,
   input  wire logic [LEVEL_W-1:0]  rx_threshold,
   output logic      [1:0]          speed_select,
   output logic      [COUNT_W-1:0]  scl_high_count,
   output logic      [COUNT_W-1:0]  scl_low_count,
   output logic                     event_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State of the block, held as one packed record.

   typedef struct packed {
      logic                sda_s1;
      logic                sda_s2;
      logic                sda_q;
      logic                scl_s1;
      logic                scl_s2;
      logic [COUNT_W-1:0]  std_high;
      logic [COUNT_W-1:0]  std_low;
      logic [COUNT_W-1:0]  fast_high;
      logic [COUNT_W-1:0]  fast_low;
      logic [COUNT_W-1:0]  hs_high;
      logic [COUNT_W-1:0]  hs_low;
      logic [1:0]          speed;
      logic [EVENT_W-1:0]  mask;
      logic [EVENT_W-1:0]  raw;
      logic [COUNT_W-1:0]  sel_high;
      logic [COUNT_W-1:0]  sel_low;
      logic [31:0]         rdata;
      logic                err;
      logic                irq;
   } state_type;

   state_type state_reg;
   state_type state_next;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Merges the low two byte lanes of a write into a 16-bit field.
   function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                           input logic [31:0] wdata,
                                           input logic [3:0]  strb);
      logic [15:0] res;
      res = old_val;
      if (strb[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res;
   endfunction

   // Tells whether an offset belongs to the register map.
   function automatic logic is_mapped(input logic [7:0] addr);
      case (addr)
         OFFS_CONTROL, OFFS_STD_SCL_HIGH, OFFS_STD_SCL_LOW, OFFS_FAST_SCL_HIGH,
         OFFS_FAST_SCL_LOW, OFFS_HS_SCL_HIGH, OFFS_HS_SCL_LOW, OFFS_MASKED_STAT,
         OFFS_EVENT_MASK, OFFS_UNMASKED_STAT, OFFS_CLEAR_ALL: begin
            return 1'b1;
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Handshake and outputs.

   logic setup_phase;
   logic access_done;
   logic start_cond;
   logic stop_cond;
   logic [EVENT_W-1:0] set_events;
   logic [EVENT_W-1:0] masked_now;

   // The slave answers in the first access cycle unless the block is frozen.
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & clk_en;
   assign pready      = psel & penable & clk_en;

   // Read data and error were captured during setup so they come from flops.
   assign prdata         = state_reg.rdata;
   assign pslverr        = state_reg.err & pready;
   assign speed_select   = state_reg.speed;
   assign scl_high_count = state_reg.sel_high;
   assign scl_low_count  = state_reg.sel_low;
   assign event_irq      = state_reg.irq;

   assign masked_now = state_reg.raw & state_reg.mask;

   ////////////////////////////////////////////////////////////////////////////
   // Bus conditions seen on the synchronised pins.

   // SDA falling while SCL is high is a START or repeated START.
   assign start_cond = state_reg.scl_s2 & state_reg.sda_q & ~state_reg.sda_s2;
   // SDA rising while SCL is high is a STOP.
   assign stop_cond  = state_reg.scl_s2 & ~state_reg.sda_q & state_reg.sda_s2;

   ////////////////////////////////////////////////////////////////////////////
   // Event set terms, one per sticky bit.

   always_comb begin
      set_events                = '0;
      set_events[BIT_GEN_CALL]  = gen_call_acked;
      set_events[BIT_START]     = start_cond;
      set_events[BIT_STOP]      = stop_cond;
      set_events[BIT_ACTIVITY]  = bus_active | start_cond;
      set_events[BIT_TX_DONE]   = slave_tx_nack;
      set_events[BIT_TX_ABORT]  = tx_abort_event;
      set_events[BIT_READ_REQ]  = read_request_event;
      set_events[BIT_TX_OVER]   = data_cmd_write & tx_fifo_full;
      set_events[BIT_RX_OVER]   = rx_byte_arrived & rx_fifo_full;
      set_events[BIT_RX_UNDER]  = data_cmd_read & rx_fifo_empty;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      logic       clear_all;
      logic [7:0] addr;
      state_next = state_reg;
      clear_all  = 1'b0;
      addr       = paddr;

      // Pins pass two flops; the second stage and a third SDA flop feed the edge logic.
      state_next.sda_s1 = sda_in;
      state_next.sda_s2 = state_reg.sda_s1;
      state_next.sda_q  = state_reg.sda_s2;
      state_next.scl_s1 = scl_in;
      state_next.scl_s2 = state_reg.scl_s1;

      // Read data and the error answer are prepared in the setup cycle.
      if (setup_phase) begin
         state_next.err   = ~is_mapped(addr);
         state_next.rdata = 32'h0000_0000;
         case (addr)
            OFFS_CONTROL: begin
               state_next.rdata[SPEED_LSB +: 2] = state_reg.speed;
            end
            OFFS_STD_SCL_HIGH: begin
               state_next.rdata[COUNT_W-1:0] = state_reg.std_high;
            end
            OFFS_STD_SCL_LOW: begin
               state_next.rdata[COUNT_W-1:0] = state_reg.std_low;
            end
            OFFS_FAST_SCL_HIGH: begin
               state_next.rdata[COUNT_W-1:0] = state_reg.fast_high;
            end
            OFFS_FAST_SCL_LOW: begin
               state_next.rdata[COUNT_W-1:0] = state_reg.fast_low;
            end
            OFFS_HS_SCL_HIGH: begin
               state_next.rdata[COUNT_W-1:0] = state_reg.hs_high;
            end
            OFFS_HS_SCL_LOW: begin
               state_next.rdata[COUNT_W-1:0] = state_reg.hs_low;
            end
            OFFS_MASKED_STAT: begin
               state_next.rdata[EVENT_W-1:0] = masked_now;
            end
            OFFS_EVENT_MASK: begin
               state_next.rdata[EVENT_W-1:0] = state_reg.mask;
            end
            OFFS_UNMASKED_STAT: begin
               state_next.rdata[EVENT_W-1:0] = state_reg.raw;
            end
            OFFS_CLEAR_ALL: begin
               state_next.rdata[0] = state_reg.irq;
            end
            default: begin
               state_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Writes take effect at the access edge; read-only offsets ignore them.
      if (access_done && pwrite) begin
         case (addr)
            OFFS_CONTROL: begin
               if (pstrb[0]) begin
                  state_next.speed = pwdata[SPEED_LSB +: 2];
               end
            end
            OFFS_STD_SCL_HIGH: begin
               state_next.std_high = merge16(state_reg.std_high, pwdata, pstrb);
            end
            OFFS_STD_SCL_LOW: begin
               state_next.std_low = merge16(state_reg.std_low, pwdata, pstrb);
            end
            OFFS_FAST_SCL_HIGH: begin
               state_next.fast_high = merge16(state_reg.fast_high, pwdata, pstrb);
            end
            OFFS_FAST_SCL_LOW: begin
               state_next.fast_low = merge16(state_reg.fast_low, pwdata, pstrb);
            end
            OFFS_HS_SCL_HIGH: begin
               state_next.hs_high = merge16(state_reg.hs_high, pwdata, pstrb);
            end
            OFFS_HS_SCL_LOW: begin
               state_next.hs_low = merge16(state_reg.hs_low, pwdata, pstrb);
            end
            OFFS_EVENT_MASK: begin
               state_next.mask = 12'(merge16({4'h0, state_reg.mask}, pwdata, pstrb));
            end
            default: begin
               state_next.speed = state_reg.speed;
            end
         endcase
      end

      // A read of the clear-all register clears every sticky flag.
      if (access_done && !pwrite && addr == OFFS_CLEAR_ALL) begin
         clear_all = 1'b1;
      end

      // Sticky flags: an event in the clearing cycle still sets its bit.
      if (clear_all) begin
         state_next.raw = set_events;
      end else begin
         state_next.raw = state_reg.raw | set_events;
      end

      // Level flags follow the buffer fill and are not cleared by software.
      state_next.raw[BIT_TX_LOW] = (tx_fill <= tx_threshold);
      state_next.raw[BIT_RX_HIGH] = (rx_fill >= rx_threshold);

      // Combined interrupt follows the masked flags of the next cycle.
      state_next.irq = |(state_next.raw & state_next.mask);

      // Count pair chosen by the speed field; the unused code keeps standard.
      case (state_reg.speed)
         SPEED_FAST: begin
            state_next.sel_high = state_reg.fast_high;
            state_next.sel_low  = state_reg.fast_low;
         end
         SPEED_HIGH: begin
            state_next.sel_high = state_reg.hs_high;
            state_next.sel_low  = state_reg.hs_low;
         end
         SPEED_STANDARD: begin
            state_next.sel_high = state_reg.std_high;
            state_next.sel_low  = state_reg.std_low;
         end
         default: begin
            state_next.sel_high = state_reg.std_high;
            state_next.sel_low  = state_reg.std_low;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; the clock enable freezes everything.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.sda_s1    <= 1'b1;
         state_reg.sda_s2    <= 1'b1;
         state_reg.sda_q     <= 1'b1;
         state_reg.scl_s1    <= 1'b1;
         state_reg.scl_s2    <= 1'b1;
         state_reg.std_high  <= COUNT_RESET;
         state_reg.std_low   <= COUNT_RESET;
         state_reg.fast_high <= COUNT_RESET;
         state_reg.fast_low  <= COUNT_RESET;
         state_reg.hs_high   <= COUNT_RESET;
         state_reg.hs_low    <= COUNT_RESET;
         state_reg.speed     <= SPEED_RESET;
         state_reg.mask      <= MASK_RESET;
         state_reg.raw       <= EVENT_RESET;
         state_reg.sel_high  <= COUNT_RESET;
         state_reg.sel_low   <= COUNT_RESET;
         state_reg.rdata     <= 32'h0000_0000;
         state_reg.err       <= 1'b0;
         state_reg.irq       <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

endmodule

// ### tb/scl_event_assertions.sv
// Concurrent checks on the SCL count and event status block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/100ps
module scl_event_checker
   import scl_event_pkg::*;
(
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               clk_en,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic               pready,
   input wire logic               gen_call_acked,
   input wire logic               bus_active,
   input wire logic               slave_tx_nack,
   input wire logic               tx_abort_event,
   input wire logic               read_request_event,
   input wire logic               data_cmd_write,
   input wire logic               data_cmd_read,
   input wire logic               rx_byte_arrived,
   input wire logic [LEVEL_W-1:0] tx_fill,
   input wire logic [LEVEL_W-1:0] tx_threshold,
   input wire logic [LEVEL_W-1:0] rx_fill,
   input wire logic [LEVEL_W-1:0] rx_threshold,
   input wire logic [1:0]         speed_select,
   input wire logic [COUNT_W-1:0] scl_high_count,
   input wire logic [COUNT_W-1:0] scl_low_count,
   input wire logic               event_irq
);
   logic [11:0] mask_h;
   logic        wr_acc;
   logic        mask_wr;
   logic        clr_rd;
   logic        quiet;
   logic        lv_quiet;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode and a mask shadow; the mask itself never reaches the ports.
   assign wr_acc   = psel && penable && pready && pwrite;
   assign mask_wr  = wr_acc && paddr == OFFS_EVENT_MASK;
   assign clr_rd   = psel && penable && pready && !pwrite && paddr == OFFS_CLEAR_ALL;
   assign quiet    = !(gen_call_acked || bus_active || slave_tx_nack || tx_abort_event
                     || read_request_event || data_cmd_write || data_cmd_read || rx_byte_arrived);
   assign lv_quiet = !(mask_h[BIT_TX_LOW] && tx_fill <= tx_threshold) && mask_h[10:8] == 3'h0
                     && !(mask_h[BIT_RX_HIGH] && rx_fill >= rx_threshold);

   // Pin events are unseen here, so checks on a low output need bits 10 to 8 masked.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_h <= MASK_RESET;
      end else if (mask_wr) begin
         mask_h <= {pstrb[1] ? pwdata[11:8] : mask_h[11:8], pstrb[0] ? pwdata[7:0] : mask_h[7:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property count_follows(logic [7:0] a, logic [1:0] sp, bit hi);
      wr_acc && paddr == a && pstrb == 4'hf && speed_select == sp ##1 clk_en && speed_select == sp
      |=> (hi ? scl_high_count : scl_low_count) == $past(pwdata[15:0], 2);
   endproperty

   a_std_high: assert property (count_follows(OFFS_STD_SCL_HIGH, SPEED_STANDARD, 1'b1))
      else $error("standard high count wrong");
   a_std_low: assert property (count_follows(OFFS_STD_SCL_LOW, SPEED_STANDARD, 1'b0))
      else $error("standard low count wrong");
   a_fast_high: assert property (count_follows(OFFS_FAST_SCL_HIGH, SPEED_FAST, 1'b1))
      else $error("fast high count wrong");
   a_fast_low: assert property (count_follows(OFFS_FAST_SCL_LOW, SPEED_FAST, 1'b0))
      else $error("fast low count wrong");
   a_hs_high: assert property (count_follows(OFFS_HS_SCL_HIGH, SPEED_HIGH, 1'b1))
      else $error("high speed high count wrong");
   a_hs_low: assert property (count_follows(OFFS_HS_SCL_LOW, SPEED_HIGH, 1'b0))
      else $error("high speed low count wrong");
   a_gen_call_irq: assert property (gen_call_acked && clk_en && mask_h[BIT_GEN_CALL] |=> event_irq)
      else $error("general call did not raise interrupt");
   a_tx_level_irq: assert property (tx_fill <= tx_threshold && clk_en && mask_h[BIT_TX_LOW] |=> event_irq)
      else $error("transmit level did not raise interrupt");
   a_rx_level_irq: assert property (rx_fill >= rx_threshold && clk_en && mask_h[BIT_RX_HIGH] |=> event_irq)
      else $error("receive level did not raise interrupt");
   a_clear_all_read: assert property (clr_rd && quiet && lv_quiet |=> !event_irq)
      else $error("clear-all read left interrupt high");
   a_irq_stays_low: assert property (!event_irq && quiet && lv_quiet && !mask_wr && !$past(mask_wr) |=> !event_irq)
      else $error("interrupt rose without a cause");

   c_clear_read: cover property (clr_rd);
   c_gen_call: cover property (gen_call_acked && mask_h[BIT_GEN_CALL]);
   c_mask_write: cover property (mask_wr);
endmodule

bind scl_event_regs scl_event_checker u_scl_event_checker (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .gen_call_acked(gen_call_acked), .bus_active(bus_active), .slave_tx_nack(slave_tx_nack),
   .tx_abort_event(tx_abort_event), .read_request_event(read_request_event),
   .data_cmd_write(data_cmd_write), .data_cmd_read(data_cmd_read),
   .rx_byte_arrived(rx_byte_arrived), .tx_fill(tx_fill), .tx_threshold(tx_threshold),
   .rx_fill(rx_fill), .rx_threshold(rx_threshold), .speed_select(speed_select),
   .scl_high_count(scl_high_count), .scl_low_count(scl_low_count), .event_irq(event_irq)
);

// ### tb/i2c_bus_model.sv
// Behavioural far-side bus: one frame of START, four data bits and STOP.
// Assumes pulled-up lines, so both rest high outside the frame.
`timescale 1ns/100ps
module i2c_bus_model (
   input  wire logic go,
   output logic      scl,
   output logic      sda,
   output logic      done
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
      done = 1'b0;
   end

   // Clock period is 800 ns; data moves only while the clock is low.
   always @(posedge go) begin
      #137;
      sda = 1'b0;
      #400;
      for (int i = 0; i < 4; i++) begin
         scl = 1'b0;
         #200;
         sda = i[0];
         #200;
         scl = 1'b1;
         #400;
      end
      scl = 1'b0;
      #200;
      sda = 1'b0;
      #200;
      scl = 1'b1;
      #400;
      sda = 1'b1;
      #400;
      done = 1'b1;
   end
endmodule

// ### tb/tb_i2c_scl_timing_and_irq_status.sv
// Self-checking bench for the SCL count and event status block.
// Assumes the bus model and the checker are compiled before it.
`timescale 1ns/100ps
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_i2c_scl_timing_and_irq_status;
   import scl_event_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, go = 1'b0, done;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
   logic        tx_fifo_full = 1'b0, rx_fifo_full = 1'b0, rx_fifo_empty = 1'b0;
   logic        sda_in, scl_in, event_irq;
   logic [7:0]  paddr = 8'h00, pulse = 8'h00;
   logic [7:0]  tx_fill = 8'h05, tx_threshold = 8'h02, rx_fill = 8'h00, rx_threshold = 8'h01;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdata, e;
   logic [3:0]  pstrb = 4'hf;
   logic [1:0]  speed_select;
   logic [15:0] scl_high_count, scl_low_count;
   int          n_errors = 0, total_checks = 0, cycles = 0, k, p, s;
   int          ev_bit [8] = '{11, 8, 7, 6, 5, 3, 1, 0};

   scl_event_regs u_scl_event_regs (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sda_in(sda_in), .scl_in(scl_in),
      .gen_call_acked(pulse[0]), .bus_active(pulse[1]), .slave_tx_nack(pulse[2]),
      .tx_abort_event(pulse[3]), .read_request_event(pulse[4]), .data_cmd_write(pulse[5]),
      .data_cmd_read(pulse[7]), .tx_fifo_full(tx_fifo_full), .rx_fifo_full(rx_fifo_full),
      .rx_fifo_empty(rx_fifo_empty), .rx_byte_arrived(pulse[6]), .tx_fill(tx_fill),
      .tx_threshold(tx_threshold), .rx_fill(rx_fill), .rx_threshold(rx_threshold),
      .speed_select(speed_select), .scl_high_count(scl_high_count),
      .scl_low_count(scl_low_count), .event_irq(event_irq));

   i2c_bus_model u_i2c_bus_model (.go(go), .scl(scl_in), .sda(sda_in), .done(done));

   ////////////////////////////////////////////////////////////////////////////////
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      `CHECK_EQ(rdata, exp)
   endtask

   // A one-cycle event pulse on source i.
   task automatic pulse_ev(input int i);
      @(posedge pclk);
      pulse <= 8'h01 << i;
      @(posedge pclk);
      pulse <= 8'h00;
   endtask

   // Distinct count words; the upper half must never read back.
   function automatic logic [31:0] cnt(input int i);
      return 32'hbeef_0000 + 32'(16'h1111 * (i + 1));
   endfunction

   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and a watchdog far above the expected run of some 440 cycles.
   initial forever #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFFS_CONTROL, 32'h0000_0000);
      `CHECK_EQ(rdata[2:1], SPEED_RESET)
      for (k = 0; k < 6; k++) rd_chk(OFFS_STD_SCL_HIGH + 8'(4 * k), 32'h0000_0000);
      rd_chk(OFFS_EVENT_MASK, 32'h0000_08ff);
      rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0000);
      // Counts of each speed are written while that speed is selected.
      for (k = 0; k < 6; k++) begin
         apb(1'b1, OFFS_CONTROL, {29'h0, 2'(k / 2 + 1), 1'b0});
         apb(1'b1, OFFS_STD_SCL_HIGH + 8'(4 * k), cnt(k));
      end
      for (k = 0; k < 6; k++) rd_chk(OFFS_STD_SCL_HIGH + 8'(4 * k), cnt(k) & 32'h0000_ffff);
      // Codes 00 and 01 both pick the standard pair.
      for (k = 0; k < 4; k++) begin
         apb(1'b1, OFFS_CONTROL, {29'h0, 2'(k), 1'b0});
         repeat (2) @(posedge pclk);
         s = (k == 0) ? 0 : k - 1;
         `CHECK_EQ(speed_select, 2'(k))
         `CHECK_EQ(scl_high_count, 16'(cnt(2 * s)))
         `CHECK_EQ(scl_low_count, 16'(cnt(2 * s + 1)))
      end
      // Every pulse-driven source, first without its buffer condition, then with it.
      for (p = 0; p < 2; p++) begin
         tx_fifo_full <= p[0];
         rx_fifo_full <= p[0];
         rx_fifo_empty <= p[0];
         for (k = 0; k < 8; k++) begin
            e = (k < 5 || p == 1) ? 32'h1 << ev_bit[k] : 32'h0;
            pulse_ev(k);
            rd_chk(OFFS_UNMASKED_STAT, e);
            rd_chk(OFFS_MASKED_STAT, e & 32'(MASK_RESET));
            rd_chk(OFFS_CLEAR_ALL, {31'h0, |(e & 32'(MASK_RESET))});
            rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0000);
         end
      end
      // A masked source still shows raw but cannot interrupt.
      apb(1'b1, OFFS_EVENT_MASK, 32'h0000_0000);
      pulse_ev(0);
      @(negedge pclk);
      `CHECK_EQ(event_irq, 1'b0)
      rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0800);
      rd_chk(OFFS_MASKED_STAT, 32'h0000_0000);
      apb(1'b1, OFFS_EVENT_MASK, 32'h0000_0fff);
      rd_chk(OFFS_EVENT_MASK, 32'h0000_0fff);
      `CHECK_EQ(event_irq, 1'b1)
      rd_chk(OFFS_CLEAR_ALL, 32'h0000_0001);
      apb(1'b1, OFFS_EVENT_MASK, 32'h0000_08ff);
      // Levels exactly at their thresholds, then off them.
      tx_fill <= 8'h02;
      rx_fill <= 8'h01;
      rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0014);
      tx_fill <= 8'h03;
      rx_fill <= 8'h00;
      rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0000);
      // A framed transfer on the pins.
      go <= 1'b1;
      while (done !== 1'b1) @(posedge pclk);
      repeat (4) @(posedge pclk);
      rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0700);
      rd_chk(OFFS_CLEAR_ALL, 32'h0000_0000);
      rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0000);
      // A frozen block lets an event pulse pass unseen.
      clk_en <= 1'b0;
      pulse_ev(0);
      clk_en <= 1'b1;
      rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0000);
      // Unmapped place and a write to a read-only one.
      apb(1'b1, 8'h44, 32'hffff_ffff);
      `CHECK_EQ(rerr, 1'b1)
      rd_chk(8'h44, 32'h0000_0000);
      `CHECK_EQ(rerr, 1'b1)
      apb(1'b1, OFFS_UNMASKED_STAT, 32'hffff_ffff);
      rd_chk(OFFS_UNMASKED_STAT, 32'h0000_0000);
      end_sim();
   end
endmodule
